// ==== rtl/ptb_regs.svh ====
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PTB_ADDR_W 8
`define PTB_OFF_CTRL 8'h00
`define PTB_OFF_SCALE 8'h04
`define PTB_OFF_TARGET 8'h08
`define PTB_OFF_STATUS 8'h0C
`define PTB_OFF_TOTAL_LO 8'h10
`define PTB_OFF_TOTAL_HI 8'h14
`define PTB_OFF_BATCH 8'h18
`define PTB_OFF_RATE 8'h1C
`define PTB_OFF_DISPLAY 8'h20

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PTB_CTRL_MODE_LSB 0
`define PTB_CTRL_MODE_MSB 1
`define PTB_CTRL_RSTKEY_BIT 2
`define PTB_CTRL_PROG_BIT 3
`define PTB_STAT_STATE_LSB 0
`define PTB_STAT_STATE_MSB 1
`define PTB_STAT_RELAY_BIT 2
`define PTB_STAT_PROG_BIT 3
`define PTB_STAT_LAMP_BIT 4
`define PTB_STAT_HIGH_BIT 5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PTB_MODE_RESET 2'h0
`define PTB_SCALE_RESET 16'h0001
`define PTB_TARGET_RESET 24'h000000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PTB_CLK_MHZ 250
`define PTB_GATE_TIME_MS 1000
`define PTB_BLINK_TIME_MS 500

// ------------------------------------------------------------
// Synchronised input positions
// ------------------------------------------------------------
`define PTB_NUM_IN 7
`define PTB_IN_FLOW 0
`define PTB_IN_START 1
`define PTB_IN_STOP 2
`define PTB_IN_RESET 3
`define PTB_IN_DISP 4
`define PTB_IN_EXTRST 5
`define PTB_IN_LOCK 6

`endif

// ==== rtl/ptb_pkg.sv ====
package ptb_pkg;

  typedef enum logic [1:0] {
    PTB_IDLE = 2'b00,
    PTB_RUN = 2'b01,
    PTB_PAUSED = 2'b10,
    PTB_DONE = 2'b11
  } ptb_batch_t;

  typedef enum logic [1:0] {
    PTB_UNITS = 2'b00,
    PTB_DIV10 = 2'b01,
    PTB_DIV100 = 2'b10,
    PTB_SPLIT = 2'b11
  } ptb_dmode_t;

  typedef enum logic [1:0] {
    PTB_SCR_TOTAL = 2'b00,
    PTB_SCR_TOTAL_HI = 2'b01,
    PTB_SCR_RATE = 2'b10,
    PTB_SCR_BATCH = 2'b11
  } ptb_screen_t;

endpackage

// ==== rtl/ptb_sync_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"

module ptb_sync_edge (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`PTB_NUM_IN-1:0] raw_in,
  output logic [`PTB_NUM_IN-1:0] level,
  output logic [`PTB_NUM_IN-1:0] rise
);

  logic [`PTB_NUM_IN-1:0] meta_reg;
  logic [`PTB_NUM_IN-1:0] sync_reg;
  logic [`PTB_NUM_IN-1:0] last_reg;

  // Two-stage synchroniser, edge taken after the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  always_comb begin
    level = sync_reg;
    rise = sync_reg & ~last_reg;
  end

endmodule
`default_nettype wire

// ==== rtl/ptb_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none

module ptb_scaler (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pulse,
  input wire logic [15:0] k_factor,
  output logic unit
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic unit_reg;
  logic unit_next;

  // One unit pulse per k_factor raw pulses; zero acts as one
  always_comb begin
    count_next = count_reg;
    unit_next = 1'b0;
    if (pulse) begin
      if (count_reg + 16'h0001 >= k_factor) begin
        count_next = 16'h0000;
        unit_next = 1'b1;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
      unit_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      unit_reg <= unit_next;
    end
  end

  assign unit = unit_reg;

endmodule
`default_nettype wire

// ==== rtl/ptb_totalizer.sv ====
// Summary of operation
// - Every scaled flow pulse adds one to the running total shown on display.
// - Flow rate is units counted per gate interval, latched each interval.
// - Raw pulses are divided by a programmable pulses-per-unit factor.
// - Display shows six decimal digits, at most 999,999.
// - Display mode may show total divided by 10 or by 100.
// - Split mode shows ten-digit total as low and high five digits.
// - Reset key clears total when enabled, except after a manual stop; otherwise leaves the total alone.
// - External switch clears total; external lockout blocks program mode.
// - Program lamp is lit while program mode is active.
// - Start energises delivery relay one and counts toward target.
// - Batch count equal to target drops the relay and ends batch.
// - Start after a completed batch delivers another of same target.
// - Stop during delivery drops the relay at once.
// - Start after manual stop resumes from retained batch count.
// - Reset after manual stop clears batch count, terminating the batch.
// - Batch count clears at each new batch; total never does then.
// - Lamp blinks while running, stays dark after any stop unless program mode is active.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"

module ptb_totalizer #(
  parameter int unsigned GATE_CYCLES = `PTB_GATE_TIME_MS * `PTB_CLK_MHZ * 1000,
  parameter int unsigned BLINK_CYCLES = `PTB_BLINK_TIME_MS * `PTB_CLK_MHZ * 1000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic flow_pulse,
  input wire logic key_start,
  input wire logic key_stop,
  input wire logic key_reset,
  input wire logic key_display,
  input wire logic ext_reset_sw,
  input wire logic ext_lockout,
  input wire logic [`PTB_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic relay_deliver,
  output logic prog_lamp,
  output logic [23:0] disp_digits,
  output logic disp_high
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [39:0] bcd_inc(input logic [39:0] v);
    logic [39:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (carry) begin
        if (r[4*i+:4] == 4'h9) begin
          r[4*i+:4] = 4'h0;
        end else begin
          r[4*i+:4] = r[4*i+:4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  logic [`PTB_NUM_IN-1:0] in_level;
  logic [`PTB_NUM_IN-1:0] in_rise;
  logic unit_pulse;

  ptb_sync_edge u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .raw_in({ext_lockout, ext_reset_sw, key_display, key_reset, key_stop, key_start,
             flow_pulse}),
    .level(in_level),
    .rise(in_rise)
  );

  logic [15:0] scale_reg;

  ptb_scaler u_scale (
    .clock(clock),
    .rst_b(rst_b),
    .pulse(in_rise[`PTB_IN_FLOW]),
    .k_factor(scale_reg),
    .unit(unit_pulse)
  );

  logic start_rise;
  logic stop_rise;
  logic reset_rise;
  logic disp_rise;
  logic extrst_rise;
  logic locked;

  assign start_rise = in_rise[`PTB_IN_START];
  assign stop_rise = in_rise[`PTB_IN_STOP];
  assign reset_rise = in_rise[`PTB_IN_RESET];
  assign disp_rise = in_rise[`PTB_IN_DISP];
  assign extrst_rise = in_rise[`PTB_IN_EXTRST];
  assign locked = in_level[`PTB_IN_LOCK];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ptb_pkg::ptb_dmode_t mode_reg, mode_next;
  ptb_pkg::ptb_batch_t state_reg, state_next;
  ptb_pkg::ptb_screen_t screen_reg, screen_next;
  logic rstkey_en_reg, rstkey_en_next;
  logic prog_req_reg, prog_req_next;
  logic [15:0] scale_next;
  logic [23:0] target_reg, target_next;
  logic [39:0] total_reg, total_next;
  logic [23:0] batch_reg, batch_next;
  logic [23:0] rate_acc_reg, rate_acc_next;
  logic [23:0] rate_reg, rate_next;
  logic [27:0] gate_cnt_reg, gate_cnt_next;
  logic [27:0] blink_cnt_reg, blink_cnt_next;
  logic blink_reg, blink_next;
  logic relay_reg, relay_next;
  logic lamp_reg, lamp_next;
  logic [23:0] disp_reg, disp_next;
  logic high_reg, high_next;
  logic [31:0] rdata_reg, rdata_next;
  logic prog_mode;
  logic [39:0] total_inc;
  logic [23:0] batch_inc;
  logic [23:0] rate_inc;
  logic [31:0] read_val;
  logic [39:0] batch_wide, rate_wide;

  assign total_inc = bcd_inc(total_reg);
  assign batch_wide = bcd_inc({16'h0000, batch_reg});
  assign rate_wide = bcd_inc({16'h0000, rate_acc_reg});
  assign batch_inc = batch_wide[23:0];
  assign rate_inc = rate_wide[23:0];
  // Program mode refused while delivering or when locked out
  assign prog_mode = prog_req_reg & ~locked & (state_reg != ptb_pkg::PTB_RUN);

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always_comb begin
    case (addr)
      `PTB_OFF_CTRL: read_val = {28'h0000000, prog_req_reg, rstkey_en_reg, mode_reg};
      `PTB_OFF_SCALE: read_val = {16'h0000, scale_reg};
      `PTB_OFF_TARGET: read_val = {8'h00, target_reg};
      `PTB_OFF_STATUS: read_val = {26'h0000000, high_reg, lamp_reg, prog_mode, relay_reg,
                                   state_reg};
      `PTB_OFF_TOTAL_LO: read_val = total_reg[31:0];
      `PTB_OFF_TOTAL_HI: read_val = {24'h000000, total_reg[39:32]};
      `PTB_OFF_BATCH: read_val = {8'h00, batch_reg};
      `PTB_OFF_RATE: read_val = {8'h00, rate_reg};
      `PTB_OFF_DISPLAY: read_val = {8'h00, disp_reg};
      default: read_val = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    rstkey_en_next = rstkey_en_reg;
    prog_req_next = prog_req_reg;
    scale_next = scale_reg;
    target_next = target_reg;
    state_next = state_reg;
    total_next = total_reg;
    batch_next = batch_reg;
    rate_acc_next = rate_acc_reg;
    rate_next = rate_reg;
    gate_cnt_next = gate_cnt_reg + 28'h0000001;
    blink_cnt_next = blink_cnt_reg + 28'h0000001;
    blink_next = blink_reg;
    screen_next = screen_reg;
    rdata_next = rd_en ? read_val : 32'h00000000;

    if (wr_en) begin
      case (addr)
        `PTB_OFF_CTRL: begin
          mode_next = ptb_pkg::ptb_dmode_t'(wdata[`PTB_CTRL_MODE_MSB:`PTB_CTRL_MODE_LSB]);
          rstkey_en_next = wdata[`PTB_CTRL_RSTKEY_BIT];
          prog_req_next = wdata[`PTB_CTRL_PROG_BIT];
        end
        `PTB_OFF_SCALE: scale_next = wdata[15:0];
        `PTB_OFF_TARGET: target_next = wdata[23:0];
        default: ;
      endcase
    end

    // Grand total keeps counting through every batch
    if (unit_pulse) begin
      total_next = total_inc;
    end
    if (extrst_rise) begin
      total_next = 40'h0000000000;
    end else if (reset_rise && rstkey_en_reg && state_reg != ptb_pkg::PTB_PAUSED) begin
      total_next = 40'h0000000000;
    end

    case (state_reg)
      ptb_pkg::PTB_IDLE, ptb_pkg::PTB_DONE: begin
        if (start_rise && !stop_rise && !prog_mode) begin
          state_next = ptb_pkg::PTB_RUN;
          batch_next = 24'h000000;
          blink_cnt_next = 28'h0000000;
          blink_next = 1'b1;
        end
      end
      ptb_pkg::PTB_RUN: begin
        if (stop_rise) begin
          state_next = ptb_pkg::PTB_PAUSED;
        end else if (batch_reg == target_reg) begin
          state_next = ptb_pkg::PTB_DONE;
        end else if (unit_pulse) begin
          batch_next = batch_inc;
        end
      end
      ptb_pkg::PTB_PAUSED: begin
        if (reset_rise) begin
          state_next = ptb_pkg::PTB_IDLE;
          batch_next = 24'h000000;
        end else if (start_rise && !stop_rise && !prog_mode) begin
          state_next = ptb_pkg::PTB_RUN;
        end
      end
      default: state_next = ptb_pkg::PTB_IDLE;
    endcase

    // Rate gate: units per interval
    if (gate_cnt_reg == 28'(GATE_CYCLES - 1)) begin
      gate_cnt_next = 28'h0000000;
      rate_next = unit_pulse ? rate_inc : rate_acc_reg;
      rate_acc_next = 24'h000000;
    end else if (unit_pulse) begin
      rate_acc_next = rate_inc;
    end

    if (blink_cnt_reg == 28'(BLINK_CYCLES - 1)) begin
      blink_cnt_next = 28'h0000000;
      blink_next = ~blink_reg;
    end

    // Display key walks the screens; high half only in split mode
    if (disp_rise) begin
      case (screen_reg)
        ptb_pkg::PTB_SCR_TOTAL:
          screen_next = (mode_reg == ptb_pkg::PTB_SPLIT) ? ptb_pkg::PTB_SCR_TOTAL_HI
                                                          : ptb_pkg::PTB_SCR_RATE;
        ptb_pkg::PTB_SCR_TOTAL_HI: screen_next = ptb_pkg::PTB_SCR_RATE;
        ptb_pkg::PTB_SCR_RATE: screen_next = ptb_pkg::PTB_SCR_BATCH;
        default: screen_next = ptb_pkg::PTB_SCR_TOTAL;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Output logic
  // ------------------------------------------------------------
  always_comb begin
    relay_next = (state_next == ptb_pkg::PTB_RUN);
    if (prog_mode) begin
      lamp_next = 1'b1;
    end else if (state_reg == ptb_pkg::PTB_RUN) begin
      lamp_next = blink_reg;
    end else begin
      lamp_next = 1'b0;
    end
    high_next = 1'b0;
    case (screen_reg)
      ptb_pkg::PTB_SCR_TOTAL: begin
        case (mode_reg)
          ptb_pkg::PTB_DIV10: disp_next = total_reg[27:4];
          ptb_pkg::PTB_DIV100: disp_next = total_reg[31:8];
          ptb_pkg::PTB_SPLIT: disp_next = {4'h0, total_reg[19:0]};
          default: disp_next = total_reg[23:0];
        endcase
      end
      ptb_pkg::PTB_SCR_TOTAL_HI: begin
        disp_next = {4'h0, total_reg[39:20]};
        high_next = 1'b1;
      end
      ptb_pkg::PTB_SCR_RATE: disp_next = rate_reg;
      default: disp_next = batch_reg;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= ptb_pkg::PTB_UNITS;
      rstkey_en_reg <= 1'b0;
      prog_req_reg <= 1'b0;
      scale_reg <= `PTB_SCALE_RESET;
      target_reg <= `PTB_TARGET_RESET;
      state_reg <= ptb_pkg::PTB_IDLE;
      total_reg <= 40'h0000000000;
      batch_reg <= 24'h000000;
      rate_acc_reg <= 24'h000000;
      rate_reg <= 24'h000000;
      gate_cnt_reg <= 28'h0000000;
      blink_cnt_reg <= 28'h0000000;
      blink_reg <= 1'b0;
      screen_reg <= ptb_pkg::PTB_SCR_TOTAL;
      relay_reg <= 1'b0;
      lamp_reg <= 1'b0;
      disp_reg <= 24'h000000;
      high_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      mode_reg <= mode_next;
      rstkey_en_reg <= rstkey_en_next;
      prog_req_reg <= prog_req_next;
      scale_reg <= scale_next;
      target_reg <= target_next;
      state_reg <= state_next;
      total_reg <= total_next;
      batch_reg <= batch_next;
      rate_acc_reg <= rate_acc_next;
      rate_reg <= rate_next;
      gate_cnt_reg <= gate_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
      screen_reg <= screen_next;
      relay_reg <= relay_next;
      lamp_reg <= lamp_next;
      disp_reg <= disp_next;
      high_reg <= high_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign relay_deliver = relay_reg;
  assign prog_lamp = lamp_reg;
  assign disp_digits = disp_reg;
  assign disp_high = high_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_new_start;
    (state_reg == ptb_pkg::PTB_IDLE || state_reg == ptb_pkg::PTB_DONE) &&
      start_rise && !stop_rise && !prog_mode;
  endsequence

  sequence s_run_stop;
    state_reg == ptb_pkg::PTB_RUN && stop_rise;
  endsequence

  sequence s_resume;
    state_reg == ptb_pkg::PTB_PAUSED && start_rise && !stop_rise && !reset_rise && !prog_mode;
  endsequence

  chk_start_relay_on: assert property (
      s_new_start |=> relay_deliver && batch_reg == 24'h000000)
    else $error("start did not energise relay with cleared batch");
  chk_stop_relay_off: assert property (s_run_stop |=> !relay_deliver &&
      state_reg == ptb_pkg::PTB_PAUSED)
    else $error("stop did not drop relay");
  chk_target_end: assert property (state_reg == ptb_pkg::PTB_RUN && !stop_rise &&
      batch_reg == target_reg |=> !relay_deliver && state_reg == ptb_pkg::PTB_DONE)
    else $error("batch did not end at target");
  chk_resume_keep: assert property (s_resume |=> relay_deliver &&
      batch_reg == $past(batch_reg))
    else $error("resume lost batch count");
  chk_terminate_clear: assert property (
      state_reg == ptb_pkg::PTB_PAUSED && reset_rise |=>
      state_reg == ptb_pkg::PTB_IDLE && batch_reg == 24'h000000 && !relay_deliver)
    else $error("terminate did not clear batch");
  chk_total_count: assert property (unit_pulse && !extrst_rise && !reset_rise |=>
      total_reg == bcd_inc($past(total_reg)))
    else $error("total missed a unit");
  chk_prog_lamp_on: assert property (prog_mode |=> prog_lamp)
    else $error("program lamp dark in program mode");
  chk_lamp_dark_stop: assert property (
      (state_reg != ptb_pkg::PTB_RUN && !prog_mode)[*2] |-> !prog_lamp)
    else $error("lamp lit after stop");
  chk_split_high: assert property (screen_reg == ptb_pkg::PTB_SCR_TOTAL_HI |=>
      disp_high && disp_digits == {4'h0, $past(total_reg[39:20])})
    else $error("high half screen wrong");
  chk_div10_view: assert property (screen_reg == ptb_pkg::PTB_SCR_TOTAL &&
      mode_reg == ptb_pkg::PTB_DIV10 |=> disp_digits == $past(total_reg[27:4]))
    else $error("divide by ten view wrong");
  chk_read_idle: assert property (!rd_en |=> rdata == 32'h00000000)
    else $error("read data outside read cycle");

endmodule
`default_nettype wire

// ==== verification/ptb_flow_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Flowmeter and front-panel keys
// ------------------------------------------------------------
module ptb_flow_model (
  input wire logic clock,
  output logic flow_pulse,
  output logic key_start,
  output logic key_stop,
  output logic key_reset,
  output logic key_display,
  output logic ext_reset_sw,
  output logic ext_lockout
);
  logic [6:0] pin_q = 7'h00;

  // Pins follow the requested levels one edge later
  always @(posedge clock) begin
    {ext_lockout, ext_reset_sw, key_display, key_reset} <= pin_q[6:3];
    {key_stop, key_start, flow_pulse} <= pin_q[2:0];
  end

  // Meter pulse: two cycles high, two low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      pin_q[0] <= 1'b1;
      repeat (2) @(posedge clock);
      pin_q[0] <= 1'b0;
      @(posedge clock);
    end
  endtask

  // Key codes: 0 start, 1 stop, 2 reset, 3 display, 4 external clear
  // Held three cycles, released three, so every press is a clean edge
  task automatic press(input int k);
    @(posedge clock);
    pin_q[k + 1] <= 1'b1;
    repeat (3) @(posedge clock);
    pin_q[k + 1] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic lock(input logic v);
    @(posedge clock);
    pin_q[6] <= v;
  endtask
endmodule

`default_nettype wire

// ==== verification/test_pulse_totalizer_batch_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"

module test_pulse_totalizer_batch_control;
  typedef struct {logic [1:0] mode; logic [23:0] exp;} ptb_row_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [`PTB_ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic flow_pulse, key_start, key_stop, key_reset, key_display, ext_reset_sw, ext_lockout;
  logic relay_deliver, prog_lamp, disp_high;
  logic [23:0] disp_digits;
  int err_total = 0;
  int tests_run = 0;
  int hi, lo;
  ptb_row_t rows [4] = '{'{2'h0, 24'h001234}, '{2'h1, 24'h000123},
                         '{2'h2, 24'h000012}, '{2'h3, 24'h001234}};

  always #2 clock = ~clock;

  ptb_flow_model FM (.clock(clock), .flow_pulse(flow_pulse), .key_start(key_start),
    .key_stop(key_stop), .key_reset(key_reset), .key_display(key_display),
    .ext_reset_sw(ext_reset_sw), .ext_lockout(ext_lockout));

  ptb_totalizer #(.GATE_CYCLES(100), .BLINK_CYCLES(8)) DUT (.clock(clock), .rst_b(rst_b),
    .flow_pulse(flow_pulse), .key_start(key_start), .key_stop(key_stop),
    .key_reset(key_reset), .key_display(key_display), .ext_reset_sw(ext_reset_sw),
    .ext_lockout(ext_lockout), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .relay_deliver(relay_deliver), .prog_lamp(prog_lamp),
    .disp_digits(disp_digits), .disp_high(disp_high));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [`PTB_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [`PTB_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic relay_is(input logic e);
    int i;
    i = 0;
    while (relay_deliver !== e && i < 40) begin
      @(posedge clock);
      #1 i++;
    end
    chk(32'(relay_deliver), 32'(e));
  endtask

  task automatic lamp(output int h, output int l);
    h = 0;
    l = 0;
    repeat (24) begin
      @(posedge clock);
      #1 if (prog_lamp === 1'b1) h++;
      else l++;
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(`PTB_OFF_CTRL, v); chk(v, 32'h0);
    rd(`PTB_OFF_SCALE, v); chk(v, 32'h1);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h0);
    rd(8'hFC, v); chk(v, 32'h0);
    chk(32'(relay_deliver), 32'h0);
    $display("test reset done");
    FM.pulses(1234);
    wt(8);
    foreach (rows[i]) begin
      wr(`PTB_OFF_CTRL, {30'h0, rows[i].mode});
      wt(4);
      chk(32'(disp_digits), 32'(rows[i].exp));
    end
    FM.press(3);
    wt(6);
    chk(32'(disp_high), 32'h1);
    chk(32'(disp_digits), 32'h0);
    repeat (3) FM.press(3);
    wr(`PTB_OFF_CTRL, 32'h0);
    wt(6);
    chk(32'(disp_digits), 32'h001234);
    $display("test display done");
    fork
      FM.pulses(60);
    join_none
    wt(220);
    rd(`PTB_OFF_RATE, v); chk(32'(v inside {[32'h24:32'h26]}), 32'h1);
    wait fork;
    wr(`PTB_OFF_SCALE, 32'hFFFF0002);
    FM.pulses(6);
    wr(`PTB_OFF_SCALE, 32'h1);
    wt(6);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h1297);
    $display("test rate and scale done");
    wr(`PTB_OFF_TARGET, 32'hFF000003);
    FM.press(0);
    relay_is(1'b1);
    lamp(hi, lo);
    chk(32'(hi > 0 && lo > 0), 32'h1);
    FM.pulses(3);
    relay_is(1'b0);
    rd(`PTB_OFF_STATUS, v); chk(32'(v[1:0]), 32'h3);
    rd(`PTB_OFF_BATCH, v); chk(v, 32'h3);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h1300);
    $display("test batch done");
    FM.press(0);
    relay_is(1'b1);
    rd(`PTB_OFF_BATCH, v); chk(v, 32'h0);
    FM.pulses(1);
    wt(4);
    FM.press(1);
    chk(32'(relay_deliver), 32'h0);
    lamp(hi, lo);
    chk(32'(hi), 32'h0);
    rd(`PTB_OFF_STATUS, v); chk(32'(v[1:0]), 32'h2);
    FM.press(0);
    chk(32'(relay_deliver), 32'h1);
    rd(`PTB_OFF_BATCH, v); chk(v, 32'h1);
    FM.pulses(2);
    relay_is(1'b0);
    rd(`PTB_OFF_BATCH, v); chk(v, 32'h3);
    $display("test stop and resume done");
    FM.press(0);
    FM.pulses(1);
    wt(4);
    FM.press(1);
    FM.press(2);
    wt(4);
    rd(`PTB_OFF_STATUS, v); chk(32'(v[1:0]), 32'h0);
    rd(`PTB_OFF_BATCH, v); chk(v, 32'h0);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h1304);
    $display("test terminate done");
    FM.press(2);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h1304);
    wr(`PTB_OFF_CTRL, 32'h4);
    FM.press(2);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h0);
    FM.pulses(5);
    wt(4);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h5);
    FM.press(4);
    rd(`PTB_OFF_TOTAL_LO, v); chk(v, 32'h0);
    $display("test clears done");
    wr(`PTB_OFF_CTRL, 32'h0);
    FM.lock(1'b1);
    wt(4);
    wr(`PTB_OFF_CTRL, 32'h8);
    wt(6);
    rd(`PTB_OFF_STATUS, v); chk(32'(v[3]), 32'h0);
    chk(32'(prog_lamp), 32'h0);
    FM.lock(1'b0);
    wt(6);
    rd(`PTB_OFF_STATUS, v); chk(32'(v[3]), 32'h1);
    chk(32'(prog_lamp), 32'h1);
    $display("test lockout done");
    wt(1);
    rst_b <= 1'b0;
    wt(3);
    rst_b <= 1'b1;
    rd(`PTB_OFF_CTRL, v); chk(v, 32'h0);
    chk(32'(prog_lamp), 32'h0);
    chk(32'(relay_deliver), 32'h0);
    $display("test mid reset done");
    conclude();
  end
endmodule

`default_nettype wire
